/* weld_seq_defs.vh */
// Constants for the weld sequence and limit checker
// Assumes a 10 MHz controller clock
`ifndef WELD_SEQ_DEFS_VH
`define WELD_SEQ_DEFS_VH

// ************************************************************
// Timing
// ************************************************************
`define CLK_FREQ_HZ          32'd10000000
`define MS_PER_SEC           32'd1000
`define CYCLES_PER_MS        (`CLK_FREQ_HZ / `MS_PER_SEC)

// ************************************************************
// Register byte offsets
// ************************************************************
`define OFS_CONTROL          8'h00
`define OFS_STATUS           8'h04
`define OFS_POST_TIME        8'h08
`define OFS_COOL_TIME        8'h0c
`define OFS_HOLD_TIME        8'h10
`define OFS_OFF_TIME         8'h14
`define OFS_POST_AMP         8'h18
`define OFS_POST_SLICE       8'h1c
`define OFS_POST_VOLT        8'h20
`define OFS_POST_WATT        8'h24
`define OFS_LIMIT_BASE       8'h40
`define LIMIT_COUNT          12

// ************************************************************
// Control register fields
// ************************************************************
`define CTL_MODE_LSB         0
`define CTL_CHECK_LSB        4
`define CTL_GAP_LSB          8
`define CTL_POST_EN_BIT      12
`define CTL_RESET            32'h00000000

// ************************************************************
// Regulation modes
// ************************************************************
`define MODE_CONST_CURRENT   3'h0
`define MODE_PHASE_ANGLE     3'h1
`define MODE_CONST_VOLTAGE   3'h2
`define MODE_CONST_WATTAGE   3'h3
`define MODE_JOULE           3'h4
`define MODE_ADAPTIVE        3'h5

// ************************************************************
// Checked quantity select
// ************************************************************
`define CHK_NONE             3'h0
`define CHK_AMPERAGE         3'h1
`define CHK_SLICING          3'h2
`define CHK_VOLTAGE          3'h3
`define CHK_WATTAGE          3'h4
`define CHK_JOULE            3'h5

// ************************************************************
// Thickness check select
// ************************************************************
`define GAP_OFF              2'h0
`define GAP_CHECK            2'h1
`define GAP_AND_SINK_CHECK   2'h2

`endif

/* weld_sequence_limit_checker.v */
// Weld sequence timing (post interval, hold, repeat) and quality limit checks
// Assumes Avalon-MM master on clock_in, sensors and start input from pins
//
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
`include "weld_seq_defs.vh"

module weld_sequence_limit_checker #(
	parameter DW       = 16,
	parameter MS_W     = 14,
	parameter MS_CYCLES = `CYCLES_PER_MS
) (
	// Clock and reset
	input  wire          clock_in,
	input  wire          srst_in,
	// Avalon-MM slave
	input  wire [7:0]    avs_address_in,
	input  wire          avs_read_in,
	input  wire          avs_write_in,
	input  wire [31:0]   avs_writedata_in,
	output wire [31:0]   avs_readdata_out,
	output wire          avs_waitrequest_out,
	// Operator and sequencer
	input  wire          start_cycle_in,
	input  wire          main_weld_done_in,
	// Measurements
	input  wire [DW-1:0] meas_current_in,
	input  wire [DW-1:0] meas_slicing_in,
	input  wire [DW-1:0] meas_voltage_in,
	input  wire [DW-1:0] meas_power_in,
	input  wire [DW-1:0] meas_energy_in,
	input  wire [DW-1:0] meas_gap_in,
	// Power stage and actuator
	output reg           main_weld_start_out,
	output reg           current_on_out,
	output reg  [2:0]    regulation_mode_out,
	output reg  [DW-1:0] setpoint_out,
	output reg           electrodes_closed_out,
	output reg           cycle_end_out,
	output reg           weld_error_out
);

	// ************************************************************
	// States
	// ************************************************************
	localparam [7:0] S_IDLE  = 8'h01;
	localparam [7:0] S_GAP   = 8'h02;
	localparam [7:0] S_MAIN  = 8'h04;
	localparam [7:0] S_COOL  = 8'h08;
	localparam [7:0] S_POST  = 8'h10;
	localparam [7:0] S_HOLD  = 8'h20;
	localparam [7:0] S_OFF   = 8'h40;
	localparam [7:0] S_WREL  = 8'h80;

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	reg [2:0]          start_sync_r;
	reg [2:0]          done_sync_r;
	reg [6*DW-1:0]     meas_s1_r;
	reg [6*DW-1:0]     meas_s2_r;
	wire               start_lvl = start_sync_r[1];
	wire               done_rise = done_sync_r[1] & ~done_sync_r[2];

	always @(posedge clock_in) begin
		if (srst_in) begin
			start_sync_r <= 3'h0;
			done_sync_r  <= 3'h0;
			meas_s1_r    <= {6*DW{1'b0}};
			meas_s2_r    <= {6*DW{1'b0}};
		end else begin
			start_sync_r <= {start_sync_r[1:0], start_cycle_in};
			done_sync_r  <= {done_sync_r[1:0], main_weld_done_in};
			meas_s1_r    <= {meas_gap_in, meas_energy_in, meas_power_in,
			                 meas_voltage_in, meas_slicing_in, meas_current_in};
			meas_s2_r    <= meas_s1_r;
		end
	end

	wire [DW-1:0] m_cur  = meas_s2_r[0*DW +: DW];
	wire [DW-1:0] m_sli  = meas_s2_r[1*DW +: DW];
	wire [DW-1:0] m_vol  = meas_s2_r[2*DW +: DW];
	wire [DW-1:0] m_pow  = meas_s2_r[3*DW +: DW];
	wire [DW-1:0] m_ene  = meas_s2_r[4*DW +: DW];
	wire [DW-1:0] m_gap  = meas_s2_r[5*DW +: DW];

	// ************************************************************
	// Registers
	// ************************************************************
	reg  [31:0]   control_r;
	reg  [MS_W-1:0] post_ms_r;
	reg  [MS_W-1:0] cool_ms_r;
	reg  [MS_W-1:0] hold_ms_r;
	reg  [MS_W-1:0] off_ms_r;
	reg  [DW-1:0] post_sp_r [0:3];
	reg  [DW-1:0] limit_r [0:`LIMIT_COUNT-1];
	reg  [7:0]    state_r;
	reg           gap_err_r;
	reg           lim_err_r;
	reg  [31:0]   rdata_r;
	reg           rd_done_r;
	integer       i;

	wire [2:0] mode_sel  = control_r[`CTL_MODE_LSB +: 3];
	wire [2:0] check_sel = control_r[`CTL_CHECK_LSB +: 3];
	wire [1:0] gap_sel   = control_r[`CTL_GAP_LSB +: 2];
	wire       post_en   = control_r[`CTL_POST_EN_BIT];
	wire [3:0] lim_idx   = avs_address_in[5:2];
	wire       lim_hit   = (avs_address_in[7:6] == 2'h1) && (lim_idx < `LIMIT_COUNT);

	// Reads take one wait state; writes complete at once
	assign avs_waitrequest_out = avs_read_in & ~rd_done_r;
	assign avs_readdata_out    = rdata_r;

	always @(posedge clock_in) begin
		if (srst_in) begin
			control_r <= `CTL_RESET;
			post_ms_r <= {MS_W{1'b0}};
			cool_ms_r <= {MS_W{1'b0}};
			hold_ms_r <= {MS_W{1'b0}};
			off_ms_r  <= {MS_W{1'b0}};
			for (i = 0; i < 4; i = i + 1) begin
				post_sp_r[i] <= {DW{1'b0}};
			end
			for (i = 0; i < `LIMIT_COUNT; i = i + 1) begin
				limit_r[i] <= {DW{1'b0}};
			end
		end else if (avs_write_in) begin
			case (avs_address_in)
			`OFS_CONTROL:    control_r <= avs_writedata_in;
			`OFS_POST_TIME:  post_ms_r <= avs_writedata_in[MS_W-1:0];
			`OFS_COOL_TIME:  cool_ms_r <= avs_writedata_in[MS_W-1:0];
			`OFS_HOLD_TIME:  hold_ms_r <= avs_writedata_in[MS_W-1:0];
			`OFS_OFF_TIME:   off_ms_r  <= avs_writedata_in[MS_W-1:0];
			`OFS_POST_AMP:   post_sp_r[0] <= avs_writedata_in[DW-1:0];
			`OFS_POST_SLICE: post_sp_r[1] <= avs_writedata_in[DW-1:0];
			`OFS_POST_VOLT:  post_sp_r[2] <= avs_writedata_in[DW-1:0];
			`OFS_POST_WATT:  post_sp_r[3] <= avs_writedata_in[DW-1:0];
			default: begin
				if (lim_hit) begin
					limit_r[lim_idx] <= avs_writedata_in[DW-1:0];
				end
			end
			endcase
		end
	end

	always @(posedge clock_in) begin
		if (srst_in) begin
			rdata_r   <= 32'h00000000;
			rd_done_r <= 1'b0;
		end else begin
			rd_done_r <= avs_read_in & ~rd_done_r;
			if (avs_read_in & ~rd_done_r) begin
				case (avs_address_in)
				`OFS_CONTROL:    rdata_r <= control_r;
				`OFS_STATUS:     rdata_r <= {22'h000000, gap_err_r, lim_err_r, state_r};
				`OFS_POST_TIME:  rdata_r <= {{(32-MS_W){1'b0}}, post_ms_r};
				`OFS_COOL_TIME:  rdata_r <= {{(32-MS_W){1'b0}}, cool_ms_r};
				`OFS_HOLD_TIME:  rdata_r <= {{(32-MS_W){1'b0}}, hold_ms_r};
				`OFS_OFF_TIME:   rdata_r <= {{(32-MS_W){1'b0}}, off_ms_r};
				`OFS_POST_AMP:   rdata_r <= {{(32-DW){1'b0}}, post_sp_r[0]};
				`OFS_POST_SLICE: rdata_r <= {{(32-DW){1'b0}}, post_sp_r[1]};
				`OFS_POST_VOLT:  rdata_r <= {{(32-DW){1'b0}}, post_sp_r[2]};
				`OFS_POST_WATT:  rdata_r <= {{(32-DW){1'b0}}, post_sp_r[3]};
				default:         rdata_r <= lim_hit ? {{(32-DW){1'b0}}, limit_r[lim_idx]} : 32'h00000000;
				endcase
			end
		end
	end

	// ************************************************************
	// Millisecond tick and interval counter
	// ************************************************************
	reg [23:0]     pre_r;
	reg [MS_W-1:0] ms_cnt_r;
	wire           ms_tick = (pre_r == MS_CYCLES - 1);

	always @(posedge clock_in) begin
		if (srst_in || ms_tick) begin
			pre_r <= 24'h000000;
		end else begin
			pre_r <= pre_r + 24'h000001;
		end
	end

	// ************************************************************
	// Limit evaluation
	// ************************************************************
	reg [DW-1:0] chk_val;
	reg [DW-1:0] chk_min;
	reg [DW-1:0] chk_max;
	reg          chk_on;

	always @* begin
		chk_on  = 1'b1;
		chk_val = m_cur;
		chk_min = limit_r[0];
		chk_max = limit_r[1];
		case (check_sel)
		`CHK_AMPERAGE: begin
			chk_val = m_cur;
		end
		`CHK_SLICING: begin
			chk_val = m_sli;
			chk_min = limit_r[2];
			chk_max = limit_r[3];
		end
		`CHK_VOLTAGE: begin
			chk_val = m_vol;
			chk_min = limit_r[4];
			chk_max = limit_r[5];
		end
		`CHK_WATTAGE: begin
			chk_val = m_pow;
			chk_min = limit_r[6];
			chk_max = limit_r[7];
		end
		`CHK_JOULE: begin
			chk_val = m_ene;
			chk_min = limit_r[8];
			chk_max = limit_r[9];
		end
		default: chk_on = 1'b0;
		endcase
	end

	// ************************************************************
	// Slicing average over the main weld
	// ************************************************************
	localparam SUM_CNT_W = 24;

	reg  [DW+SUM_CNT_W-1:0] sli_sum_r;
	reg  [SUM_CNT_W-1:0]    sli_cnt_r;
	wire                    sli_full = &sli_cnt_r;
	wire [DW+SUM_CNT_W-1:0] sli_lo   = {{SUM_CNT_W{1'b0}}, limit_r[2]} * {{DW{1'b0}}, sli_cnt_r};
	wire [DW+SUM_CNT_W-1:0] sli_hi   = {{SUM_CNT_W{1'b0}}, limit_r[3]} * {{DW{1'b0}}, sli_cnt_r};
	// Sum compared against limit times sample count, so no divider is needed
	wire                    sli_bad  = !((sli_sum_r > sli_lo) && (sli_sum_r < sli_hi));

	always @(posedge clock_in) begin
		if (srst_in || state_r == S_GAP) begin
			sli_sum_r <= {(DW+SUM_CNT_W){1'b0}};
			sli_cnt_r <= {SUM_CNT_W{1'b0}};
		end else if (state_r == S_MAIN && !sli_full) begin
			sli_sum_r <= sli_sum_r + {{SUM_CNT_W{1'b0}}, m_sli};
			sli_cnt_r <= sli_cnt_r + {{(SUM_CNT_W-1){1'b0}}, 1'b1};
		end
	end

	wire lim_bad = chk_on && ((check_sel == `CHK_SLICING) ? sli_bad :
	                          !((chk_val > chk_min) && (chk_val < chk_max)));
	wire gap_on  = (gap_sel == `GAP_CHECK) || (gap_sel == `GAP_AND_SINK_CHECK);
	wire gap_bad = gap_on && !((m_gap > limit_r[10]) && (m_gap < limit_r[11]));

	// ************************************************************
	// Post setpoint by regulation mode
	// ************************************************************
	reg [DW-1:0] post_sp;

	always @* begin
		case (mode_sel)
		`MODE_CONST_CURRENT, `MODE_JOULE:     post_sp = post_sp_r[0];
		`MODE_PHASE_ANGLE:                    post_sp = post_sp_r[1];
		`MODE_CONST_VOLTAGE:                  post_sp = post_sp_r[2];
		default:                              post_sp = post_sp_r[3];
		endcase
	end

	// ************************************************************
	// Sequencer
	// ************************************************************
	wire post_go  = post_en && (post_ms_r != {MS_W{1'b0}});
	wire auto_rep = (off_ms_r != {MS_W{1'b0}});
	wire ms_done  = ms_tick && (ms_cnt_r == {{(MS_W-1){1'b0}}, 1'b1});

	always @(posedge clock_in) begin
		if (srst_in) begin
			state_r               <= S_IDLE;
			ms_cnt_r              <= {MS_W{1'b0}};
			main_weld_start_out   <= 1'b0;
			current_on_out        <= 1'b0;
			regulation_mode_out   <= `MODE_CONST_CURRENT;
			setpoint_out          <= {DW{1'b0}};
			electrodes_closed_out <= 1'b0;
			cycle_end_out         <= 1'b0;
			weld_error_out        <= 1'b0;
			gap_err_r             <= 1'b0;
			lim_err_r             <= 1'b0;
		end else begin
			main_weld_start_out <= 1'b0;
			cycle_end_out       <= 1'b0;
			if (ms_tick && ms_cnt_r != {MS_W{1'b0}}) begin
				ms_cnt_r <= ms_cnt_r - {{(MS_W-1){1'b0}}, 1'b1};
			end
			case (state_r)
			S_IDLE: begin
				if (start_lvl) begin
					gap_err_r             <= 1'b0;
					lim_err_r             <= 1'b0;
					weld_error_out        <= 1'b0;
					electrodes_closed_out <= 1'b1;
					state_r               <= S_GAP;
				end
			end
			S_GAP: begin
				gap_err_r           <= gap_bad;
				weld_error_out      <= gap_bad;
				main_weld_start_out <= 1'b1;
				state_r             <= S_MAIN;
			end
			S_MAIN: begin
				if (done_rise) begin
					lim_err_r      <= lim_err_r | lim_bad;
					weld_error_out <= weld_error_out | lim_bad;
					ms_cnt_r       <= post_go ? cool_ms_r : hold_ms_r;
					state_r        <= post_go ? S_COOL : S_HOLD;
				end
			end
			S_COOL: begin
				current_on_out <= 1'b0;
				if (ms_cnt_r == {MS_W{1'b0}} || ms_done) begin
					ms_cnt_r            <= post_ms_r;
					regulation_mode_out <= mode_sel;
					setpoint_out        <= post_sp;
					current_on_out      <= 1'b1;
					state_r             <= S_POST;
				end
			end
			S_POST: begin
				if (ms_done) begin
					current_on_out <= 1'b0;
					ms_cnt_r       <= hold_ms_r;
					state_r        <= S_HOLD;
				end
			end
			S_HOLD: begin
				if (ms_cnt_r == {MS_W{1'b0}} || ms_done) begin
					electrodes_closed_out <= 1'b0;
					cycle_end_out         <= 1'b1;
					ms_cnt_r              <= off_ms_r;
					state_r               <= auto_rep ? S_OFF : S_WREL;
				end
			end
			S_OFF: begin
				if (!start_lvl) begin
					state_r <= S_IDLE;
				end else if (ms_done) begin
					state_r <= S_IDLE;
				end
			end
			S_WREL: begin
				if (!start_lvl) begin
					state_r <= S_IDLE;
				end
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end

endmodule // weld_sequence_limit_checker

/* weld_stage_model.sv */
// Power stage model: answers each main weld start with a done pulse
// Assumes start pulses from the weld block on clock_in
`timescale 1ns/1ns
module weld_stage_model (
	// Clock and reset
	input  wire clock_in,
	input  wire srst_in,
	// Weld block side
	input  wire main_weld_start_in,
	input  wire slow_in,
	output reg  main_weld_done_out
);
	// ****
	// Weld time countdown, one-cycle done pulse at the end
	// ****
	reg [7:0] cnt_r;
	always @(posedge clock_in) begin
		if (srst_in) begin
			cnt_r <= 8'h00;
			main_weld_done_out <= 1'b0;
		end else if (main_weld_start_in) begin
			cnt_r <= slow_in ? 8'h28 : 8'h06;
			main_weld_done_out <= 1'b0;
		end else begin
			cnt_r <= (cnt_r != 8'h00) ? cnt_r - 8'h01 : 8'h00;
			main_weld_done_out <= (cnt_r == 8'h01);
		end
	end
endmodule // weld_stage_model

/* weld_checker_properties.sv */
// Checker of sequencing outputs of the weld block
// Assumes bus writes seen at the ports mirror the registers
`timescale 1ns/1ns
`include "weld_seq_defs.vh"
module weld_checker #(
	parameter DW        = 16,
	parameter MS_CYCLES = 4
) (
	// Clock and reset
	input wire          clock_in,
	input wire          srst_in,
	// Bus
	input wire [7:0]    avs_address_in,
	input wire          avs_read_in,
	input wire          avs_write_in,
	input wire [31:0]   avs_writedata_in,
	input wire          avs_waitrequest_out,
	// Sequence
	input wire          start_cycle_in,
	input wire          main_weld_done_in,
	input wire          main_weld_start_out,
	input wire          current_on_out,
	input wire [2:0]    regulation_mode_out,
	input wire [DW-1:0] setpoint_out,
	input wire          electrodes_closed_out,
	input wire          cycle_end_out,
	input wire          weld_error_out
);
	reg [31:0]   ctl_r, post_r, cool_r, hold_r, off_r, on_r, idle_r, gap_r;
	reg [DW-1:0] sp_r [0:3];
	reg [DW-1:0] sp_exp;
	reg          rel_r;
	function [31:0] lo(input [31:0] n);
		lo = (n == 32'h0) ? 32'h0 : (n - 32'h1) * MS_CYCLES;
	endfunction
	// ****
	// Register mirror and interval counters
	// ****
	always @(posedge clock_in) begin
		if (srst_in) begin
			{ctl_r, post_r, cool_r, hold_r, off_r} <= 160'h0;
			{on_r, idle_r} <= 64'h0;
			gap_r <= 32'h0000ffff;
			rel_r <= 1'b1;
		end else begin
			if (avs_write_in) begin
				case (avs_address_in)
				`OFS_CONTROL:    ctl_r <= avs_writedata_in;
				`OFS_POST_TIME:  post_r <= avs_writedata_in;
				`OFS_COOL_TIME:  cool_r <= avs_writedata_in;
				`OFS_HOLD_TIME:  hold_r <= avs_writedata_in;
				`OFS_OFF_TIME:   off_r <= avs_writedata_in;
				`OFS_POST_AMP:   sp_r[0] <= avs_writedata_in[DW-1:0];
				`OFS_POST_SLICE: sp_r[1] <= avs_writedata_in[DW-1:0];
				`OFS_POST_VOLT:  sp_r[2] <= avs_writedata_in[DW-1:0];
				`OFS_POST_WATT:  sp_r[3] <= avs_writedata_in[DW-1:0];
				default: ;
				endcase
			end
			on_r <= current_on_out ? on_r + 32'h1 : 32'h0;
			idle_r <= (current_on_out || main_weld_done_in) ? 32'h0 : idle_r + 32'h1;
			gap_r <= cycle_end_out ? 32'h0 : gap_r + 32'h1;
			rel_r <= main_weld_start_out ? 1'b0 : (rel_r | ~start_cycle_in);
		end
	end
	always @* begin
		case (ctl_r[2:0])
		`MODE_PHASE_ANGLE:                 sp_exp = sp_r[1];
		`MODE_CONST_VOLTAGE:               sp_exp = sp_r[2];
		`MODE_CONST_WATTAGE, `MODE_ADAPTIVE: sp_exp = sp_r[3];
		default:                           sp_exp = sp_r[0];
		endcase
	end
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (srst_in);
	// ****
	// Properties
	// ****
	chk_read_wait: assert property (avs_read_in && avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("read wait longer than one cycle");
	chk_post_length: assert property ($fell(current_on_out) |-> on_r >= lo(post_r) && on_r <= post_r * MS_CYCLES)
		else $error("post interval length wrong");
	chk_post_zero: assert property (current_on_out |-> post_r != 32'h0)
		else $error("post current with zero duration");
	chk_post_mode: assert property (current_on_out |-> regulation_mode_out == ctl_r[2:0])
		else $error("post regulation mode wrong");
	chk_post_setpoint: assert property (current_on_out |-> setpoint_out == sp_exp)
		else $error("post setpoint wrong");
	chk_post_enable: assert property (current_on_out |-> ctl_r[`CTL_POST_EN_BIT])
		else $error("post current while disabled");
	chk_cool_gap: assert property ($rose(current_on_out) |-> idle_r >= lo(cool_r) && idle_r <= cool_r * MS_CYCLES + 8)
		else $error("cooling interval wrong");
	chk_hold_closed: assert property (current_on_out |-> electrodes_closed_out)
		else $error("electrodes open with current on");
	chk_hold_length: assert property (cycle_end_out |-> idle_r >= lo(hold_r) && idle_r <= hold_r * MS_CYCLES + 8)
		else $error("hold interval wrong");
	chk_open_after: assert property (cycle_end_out |=> !electrodes_closed_out)
		else $error("electrodes closed after cycle end");
	chk_single_release: assert property (main_weld_start_out && off_r == 32'h0 |-> rel_r)
		else $error("single cycle restarted without release");
	chk_auto_wait: assert property (main_weld_start_out && off_r != 32'h0 |-> gap_r >= lo(off_r))
		else $error("repeat wait too short");
	chk_error_sticky: assert property ($fell(weld_error_out) |-> electrodes_closed_out)
		else $error("error cleared outside a new cycle");
endmodule // weld_checker
bind weld_sequence_limit_checker weld_checker #(.DW(DW), .MS_CYCLES(MS_CYCLES)) weld_checker_inst (
	.clock_in(clock_in), .srst_in(srst_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_waitrequest_out(avs_waitrequest_out),
	.start_cycle_in(start_cycle_in), .main_weld_done_in(main_weld_done_in), .main_weld_start_out(main_weld_start_out),
	.current_on_out(current_on_out), .regulation_mode_out(regulation_mode_out), .setpoint_out(setpoint_out),
	.electrodes_closed_out(electrodes_closed_out), .cycle_end_out(cycle_end_out), .weld_error_out(weld_error_out));

/* tb_top.sv */
// Self-checking bench for the weld sequence block
// Assumes the power stage model answers main weld starts
`timescale 1ns/1ns
`include "weld_seq_defs.vh"
module tb_top;
	localparam MS = 4;
	reg         clock_in = 1'b0, srst_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0;
	reg  [7:0]  avs_address_in = 8'h00;
	reg  [31:0] avs_writedata_in = 32'h0, rdv;
	reg         start_cycle_in = 1'b0, slow_in = 1'b0;
	reg  [15:0] m_cur = 16'h0, m_sli = 16'h0, m_vol = 16'h0, m_pow = 16'h0, m_ene = 16'h0, m_gap = 16'h0;
	wire [31:0] avs_readdata_out;
	wire [2:0]  mode_w;
	wire [15:0] sp_w;
	wire        wait_w, done_w, mstart_w, on_w, closed_w, end_w, err_w;
	integer     err_total = 0, tests_run = 0, n_start = 0, n_on = 0, i, k, n0;
	always #50 clock_in = ~clock_in;
	always @(posedge clock_in) begin
		if (!srst_in) begin
			n_start <= n_start + mstart_w;
			n_on <= n_on + on_w;
		end
	end
	weld_sequence_limit_checker #(.MS_CYCLES(MS)) weld_sequence_limit_checker_inst (
		.clock_in(clock_in), .srst_in(srst_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(wait_w), .start_cycle_in(start_cycle_in), .main_weld_done_in(done_w),
		.meas_current_in(m_cur), .meas_slicing_in(m_sli), .meas_voltage_in(m_vol), .meas_power_in(m_pow),
		.meas_energy_in(m_ene), .meas_gap_in(m_gap), .main_weld_start_out(mstart_w), .current_on_out(on_w),
		.regulation_mode_out(mode_w), .setpoint_out(sp_w), .electrodes_closed_out(closed_w),
		.cycle_end_out(end_w), .weld_error_out(err_w));
	weld_stage_model weld_stage_model_inst (.clock_in(clock_in), .srst_in(srst_in),
		.main_weld_start_in(mstart_w), .slow_in(slow_in), .main_weld_done_out(done_w));
	// ****
	// Bus, compare and sequence tasks
	// ****
	task cmp(input [31:0] e, input [31:0] g);
	begin
		tests_run = tests_run + 1;
		if (g !== e) begin
			err_total = err_total + 1;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	end
	endtask
	task wr(input [7:0] a, input [31:0] d);
	begin
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= 1'b1;
		do @(posedge clock_in); while (wait_w !== 1'b0);
		avs_write_in <= 1'b0;
		@(posedge clock_in);
	end
	endtask
	task rd(input [7:0] a, output [31:0] d);
	begin
		avs_address_in <= a;
		avs_read_in <= 1'b1;
		do @(posedge clock_in); while (wait_w !== 1'b0);
		d = avs_readdata_out;
		avs_read_in <= 1'b0;
		@(posedge clock_in);
	end
	endtask
	task wait_end;
	begin
		k = 0;
		do begin
			@(posedge clock_in);
			k = k + 1;
		end while (end_w !== 1'b1 && k < 3000);
		cmp(32'h1, k < 3000);
	end
	endtask
	task wait_idle;
	begin
		start_cycle_in <= 1'b0;
		k = 0;
		do begin
			rd(`OFS_STATUS, rdv);
			k = k + 1;
		end while (rdv[7:0] !== 8'h01 && k < 50);
		cmp(32'h1, k < 50);
	end
	endtask
	task weld(input [31:0] ctl, input [15:0] v, input [15:0] g, input [31:0] e);
	begin
		wr(`OFS_CONTROL, ctl);
		m_cur <= (ctl[6:4] == `CHK_AMPERAGE) ? v : 16'h0;
		m_sli <= (ctl[6:4] == `CHK_SLICING) ? v : 16'h0;
		m_vol <= (ctl[6:4] == `CHK_VOLTAGE) ? v : 16'h0;
		m_pow <= (ctl[6:4] == `CHK_WATTAGE) ? v : 16'h0;
		m_ene <= (ctl[6:4] == `CHK_JOULE) ? v : 16'h0;
		m_gap <= g;
		start_cycle_in <= 1'b1;
		wait_end;
		cmp(e, err_w);
		wait_idle;
		cmp(e, err_w);
		cmp(e, rdv[9:8] != 2'h0);
	end
	endtask
	task close_out;
	begin
		if (err_total == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	initial begin
		#3000000;
		err_total = err_total + 1;
		close_out;
	end
	initial begin
		repeat (8) @(posedge clock_in);
		srst_in <= 1'b0;
		@(posedge clock_in);
		rd(`OFS_STATUS, rdv);
		cmp(32'h1, rdv);
		wr(8'h30, 32'h5a5a);
		rd(8'h30, rdv);
		cmp(32'h0, rdv);
		wr(`OFS_POST_TIME, 32'h2);
		wr(`OFS_COOL_TIME, 32'h1);
		wr(`OFS_HOLD_TIME, 32'h2);
		wr(`OFS_OFF_TIME, 32'h0);
		for (i = 0; i < 4; i = i + 1)
			wr(`OFS_POST_AMP + 4 * i, 32'h100 + i);
		for (i = 0; i < 12; i = i + 1)
			wr(`OFS_LIMIT_BASE + 4 * i, i[0] ? 32'hc8 : 32'h64);
		rd(`OFS_HOLD_TIME, rdv);
		cmp(32'h2, rdv);
		rd(`OFS_LIMIT_BASE + 8'h2c, rdv);
		cmp(32'hc8, rdv);
		weld(32'h0, 16'h0, 16'h0, 0);
		for (i = 1; i < 6; i = i + 1) begin
			weld(i << 4, 16'h96, 16'h0, 0);
			weld(i << 4, 16'hc8, 16'h0, 1);
			weld(i << 4, 16'h64, 16'h0, 1);
		end
		weld(32'h100, 16'h0, 16'h96, 0);
		weld(32'h100, 16'h0, 16'h64, 1);
		weld(32'h200, 16'h0, 16'hc8, 1);
		weld(32'h000, 16'h0, 16'h64, 0);
		for (i = 0; i < 6; i = i + 1) begin
			slow_in <= i[0];
			n0 = n_on;
			weld(32'h1000 | i, 16'h0, 16'h0, 0);
			cmp(32'h1, (n_on - n0 >= MS) && (n_on - n0 <= 2 * MS));
			cmp(i, mode_w);
			cmp((i == 4) ? 32'h100 : (i == 5) ? 32'h103 : 32'h100 + i, sp_w);
		end
		n0 = n_on;
		weld(32'h0, 16'h0, 16'h0, 0);
		cmp(n0, n_on);
		wr(`OFS_POST_TIME, 32'h0);
		weld(32'h1000, 16'h0, 16'h0, 0);
		cmp(n0, n_on);
		n0 = n_start;
		start_cycle_in <= 1'b1;
		wait_end;
		repeat (100) @(posedge clock_in);
		cmp(n0 + 1, n_start);
		wait_idle;
		wr(`OFS_OFF_TIME, 32'h2);
		n0 = n_start;
		start_cycle_in <= 1'b1;
		repeat (3) wait_end;
		wait_idle;
		repeat (20) @(posedge clock_in);
		cmp(n0 + 3, n_start);
		close_out;
	end
endmodule // tb_top
